// File: shared/lcfs_pkg.sv
package lcfs_pkg;
    // channel count and counter width
    localparam int NCH = 3;
    localparam int CW = 20;
    // clock period in ns
    localparam int CLK_PERIOD_NS = 25;
    // retry burst timing, as printed
    localparam int SLS_PERIOD_MS = 10;
    localparam int SLS_BURST_US = 300;
    // deglitch times in us (no figure given, plain defaults)
    localparam int REF_DEG_US = 10;
    localparam int SG_DEG_US = 10;
    localparam int OPEN_DEG_US = 10;
    localparam int SLS_DEG_US = 10;
    // cycle counts derived from the times
    localparam logic [CW-1:0] SLS_PERIOD_CYC =
        CW'(SLS_PERIOD_MS * 1000000 / CLK_PERIOD_NS);
    localparam logic [CW-1:0] SLS_BURST_CYC =
        CW'(SLS_BURST_US * 1000 / CLK_PERIOD_NS);
    localparam logic [CW-1:0] REF_DEG_CYC =
        CW'(REF_DEG_US * 1000 / CLK_PERIOD_NS);
    localparam logic [CW-1:0] SG_DEG_CYC =
        CW'(SG_DEG_US * 1000 / CLK_PERIOD_NS);
    localparam logic [CW-1:0] OPEN_DEG_CYC =
        CW'(OPEN_DEG_US * 1000 / CLK_PERIOD_NS);
    localparam logic [CW-1:0] SLS_DEG_CYC =
        CW'(SLS_DEG_US * 1000 / CLK_PERIOD_NS);

    // per-channel supervisor state, one-hot
    typedef enum logic [3:0] {
        CH_NORM = 4'h1,
        CH_SG   = 4'h2,
        CH_OPEN = 4'h4,
        CH_SLS  = 4'h8
    } lcfs_ch_t;

    // comparator and pin inputs
    typedef struct packed {
        logic ref_short_low;
        logic ref_open_low;
        logic overtemp;
        logic diag_en;
        logic fault_line;
        logic [NCH-1:0] dim;
        logic [NCH-1:0] sg_low;
        logic [NCH-1:0] sg_high;
        logic [NCH-1:0] open_low;
        logic [NCH-1:0] open_high;
        logic [NCH-1:0] sls_low;
        logic [NCH-1:0] sls_high;
    } lcfs_cmp_t;

    // status flags
    typedef struct packed {
        logic ref_short;
        logic ref_open;
        logic ext_bus_low;
        logic [NCH-1:0] sg;
        logic [NCH-1:0] open;
        logic [NCH-1:0] sls;
    } lcfs_stat_t;

    // whole state of the supervisor
    typedef struct packed {
        lcfs_cmp_t s1;
        lcfs_cmp_t s2;
        lcfs_ch_t [NCH-1:0] ch;
        logic [NCH-1:0][CW-1:0] sg_cnt;
        logic [NCH-1:0][CW-1:0] op_cnt;
        logic [NCH-1:0][CW-1:0] sl_cnt;
        logic [NCH-1:0][CW-1:0] rt_cnt;
        logic [CW-1:0] rs_cnt;
        logic [CW-1:0] ro_cnt;
        logic ref_short;
        logic ref_open;
        logic ext;
        logic [NCH-1:0] on;
        logic [NCH-1:0] retry;
        logic analog_current_setting_pin;
        logic clamp;
        logic oe;
        logic [1:0] oe_hist;
    } lcfs_state_t;

    // reset value: fault line seen idle high
    localparam lcfs_state_t LCFS_ST_RST = '{
        s1: '{fault_line: 1'b1, default: '0},
        s2: '{fault_line: 1'b1, default: '0},
        ch: {NCH{CH_NORM}},
        default: '0
    };
endpackage

// File: design/lcfs_supervisor.sv
`timescale 1ns/1ps
// Function
// - reference voltage low past deglitch: fault low, all off, clamp reference
// - reference short clears once voltage back above short threshold
// - reference current low past deglitch: fault low, channels and analog_current_setting_pin off
// - reference open clears once current back above open threshold
// - enabled channel output or sharing output low past deglitch: ground fault
// - ground-short timer restarts when outputs rise above rise threshold
// - ground fault: channel off, retry current unless globally shut off, dimming ignored
// - ground retry sees output above rise threshold: clear, resume
// - open check only with diagnostics enabled, dimming high, current on
// - short to battery is handled exactly as open circuit
// - headroom below open threshold past deglitch: open fault, fault low
// - open timer restarts when headroom rises above open fall threshold
// - open fault: stop channel, retry while diag high, resume on removal
// - single short checked while current on; off and retried while diag high
// - scaled output low past deglitch: single short fault, fault low
// - single short timer restarts above single short rise threshold
// - single short retry: full current 300 us every 10 ms, dimming high
// - burst sees output above rise threshold: clear, channel resumes
// - diagnostic enable high runs open and single checks; low disables
// - ground short and over-temperature stay active regardless of diag
// - dimming low disables channel current and its diagnostics
// - fault line pulled low externally turns all channels and retries off until high again
module lcfs_supervisor
    import lcfs_pkg::*;
#(
    parameter logic [CW-1:0] REF_TC = REF_DEG_CYC,
    parameter logic [CW-1:0] SG_TC = SG_DEG_CYC,
    parameter logic [CW-1:0] OPEN_TC = OPEN_DEG_CYC,
    parameter logic [CW-1:0] SLS_TC = SLS_DEG_CYC,
    parameter logic [CW-1:0] SLS_PERIOD = SLS_PERIOD_CYC,
    parameter logic [CW-1:0] SLS_BURST = SLS_BURST_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire lcfs_cmp_t cmp_i,
    output logic [NCH-1:0] chan_on_o,
    output logic [NCH-1:0] retry_on_o,
    output logic analog_current_setting_pin_on_o,
    output logic ref_clamp_o,
    output logic fault_line_o,
    output logic fault_line_oe_o,
    output lcfs_stat_t status_o
);

    lcfs_state_t st_q;
    lcfs_state_t st_d;
    logic goff_c;
    logic [NCH-1:0] mon_c;

    // deglitch step: restart on high, count while low, hold in band
    function automatic logic [CW-1:0] deg_step(
        input logic [CW-1:0] cnt,
        input logic low,
        input logic high,
        input logic [CW-1:0] tc
    );
        logic [CW-1:0] r;
        r = cnt;
        if (high) begin
            r = '0;
        end else if (low && cnt != tc) begin
            r = cnt + 1'b1;
        end
        return r;
    endfunction

    // global shut-off and per-channel monitoring enable
    assign goff_c = st_q.ref_short | st_q.ref_open | st_q.s2.overtemp |
                    st_q.ext;
    assign mon_c = st_q.s2.dim & {NCH{~goff_c}};

    // next-state logic
    always_comb begin
        logic [CW-1:0] n;
        logic any_ch;
        n = '0;
        any_ch = 1'b0;
        st_d = st_q;
        // two-flop synchroniser for all pins
        st_d.s1 = cmp_i;
        st_d.s2 = st_q.s1;
        // reference short detection and auto clear
        n = deg_step(st_q.rs_cnt, st_q.s2.ref_short_low,
                     ~st_q.s2.ref_short_low, REF_TC);
        st_d.rs_cnt = n;
        if (!st_q.s2.ref_short_low) begin
            st_d.ref_short = 1'b0;
        end else if (n == REF_TC) begin
            st_d.ref_short = 1'b1;
        end
        // reference open detection and auto clear
        n = deg_step(st_q.ro_cnt, st_q.s2.ref_open_low,
                     ~st_q.s2.ref_open_low, REF_TC);
        st_d.ro_cnt = n;
        if (!st_q.s2.ref_open_low) begin
            st_d.ref_open = 1'b0;
        end else if (n == REF_TC) begin
            st_d.ref_open = 1'b1;
        end
        // per-channel supervision
        for (int i = 0; i < NCH; i++) begin
            st_d.on[i] = 1'b0;
            st_d.retry[i] = 1'b0;
            case (st_q.ch[i])
                CH_NORM: begin
                    st_d.on[i] = mon_c[i];
                    st_d.rt_cnt[i] = '0;
                    // ground short watches whenever current is on
                    st_d.sg_cnt[i] = mon_c[i] ?
                        deg_step(st_q.sg_cnt[i], st_q.s2.sg_low[i],
                                 st_q.s2.sg_high[i], SG_TC) : '0;
                    // open / battery short needs diag and dimming
                    st_d.op_cnt[i] = (mon_c[i] && st_q.s2.diag_en) ?
                        deg_step(st_q.op_cnt[i], st_q.s2.open_low[i],
                                 st_q.s2.open_high[i], OPEN_TC) : '0;
                    st_d.sl_cnt[i] = (mon_c[i] && st_q.s2.diag_en) ?
                        deg_step(st_q.sl_cnt[i], st_q.s2.sls_low[i],
                                 st_q.s2.sls_high[i], SLS_TC) : '0;
                    if (st_d.sg_cnt[i] == SG_TC && st_q.s2.sg_low[i]) begin
                        st_d.ch[i] = CH_SG;
                        st_d.on[i] = 1'b0;
                    end else if (st_d.op_cnt[i] == OPEN_TC &&
                                 st_q.s2.open_low[i]) begin
                        st_d.ch[i] = CH_OPEN;
                        st_d.on[i] = 1'b0;
                    end else if (st_d.sl_cnt[i] == SLS_TC &&
                                 st_q.s2.sls_low[i]) begin
                        st_d.ch[i] = CH_SLS;
                        st_d.on[i] = 1'b0;
                    end
                    if (st_d.ch[i] != CH_NORM) begin
                        st_d.sg_cnt[i] = '0;
                        st_d.op_cnt[i] = '0;
                        st_d.sl_cnt[i] = '0;
                    end
                end
                CH_SG: begin
                    // small pull-up current, dimming ignored
                    st_d.retry[i] = ~goff_c;
                    if (st_q.s2.sg_high[i]) begin
                        st_d.ch[i] = CH_NORM;
                    end
                end
                CH_OPEN: begin
                    st_d.retry[i] = st_q.s2.diag_en & ~goff_c;
                    if (st_q.s2.open_high[i] || !st_q.s2.diag_en) begin
                        st_d.ch[i] = CH_NORM;
                    end
                end
                CH_SLS: begin
                    // burst timer wraps every period
                    st_d.rt_cnt[i] = (st_q.rt_cnt[i] == SLS_PERIOD - 1'b1) ?
                        '0 : st_q.rt_cnt[i] + 1'b1;
                    st_d.on[i] = (st_q.rt_cnt[i] < SLS_BURST) &
                                 st_q.s2.dim[i] & ~goff_c;
                    if (st_q.on[i] && st_q.s2.sls_high[i]) begin
                        st_d.ch[i] = CH_NORM;
                        st_d.on[i] = 1'b0;
                    end else if (!st_q.s2.diag_en) begin
                        st_d.ch[i] = CH_NORM;
                        st_d.on[i] = 1'b0;
                    end
                end
                default: begin
                    st_d.ch[i] = CH_NORM;
                end
            endcase
            any_ch = any_ch | (st_d.ch[i] != CH_NORM);
        end
        // reference faults kill analog_current_setting_pin and clamp on short
        st_d.analog_current_setting_pin = ~(st_d.ref_short | st_d.ref_open);
        st_d.clamp = st_d.ref_short;
        st_d.oe = any_ch | st_d.ref_short | st_d.ref_open |
                  st_q.s2.overtemp;
        // external low is a low line while we do not drive it; our own
        // pull stays in the synchroniser for two edges after release
        st_d.oe_hist = {st_q.oe_hist[0], st_q.oe};
        st_d.ext = ~st_q.s2.fault_line & ~st_q.oe & ~|st_q.oe_hist;
    end

    // state register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_q <= LCFS_ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state flops; fault line value tied low
    assign chan_on_o = st_q.on;
    assign retry_on_o = st_q.retry;
    assign analog_current_setting_pin_on_o = st_q.analog_current_setting_pin;
    assign ref_clamp_o = st_q.clamp;
    assign fault_line_o = 1'b0;
    assign fault_line_oe_o = st_q.oe;
    assign status_o.ref_short = st_q.ref_short;
    assign status_o.ref_open = st_q.ref_open;
    assign status_o.ext_bus_low = st_q.ext;

    // per-channel status and checks
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        assign status_o.sg[g] = (st_q.ch[g] == CH_SG);
        assign status_o.open[g] = (st_q.ch[g] == CH_OPEN);
        assign status_o.sls[g] = (st_q.ch[g] == CH_SLS);

        sequence s_sg_armed;
            st_q.ch[g] == CH_NORM && mon_c[g] && st_q.s2.sg_low[g] &&
            st_q.sg_cnt[g] == SG_TC - 1'b1;
        endsequence
        sequence s_sg_seen_high;
            st_q.ch[g] == CH_SG && st_q.s2.sg_high[g];
        endsequence
        sequence s_sls_past_burst;
            st_q.ch[g] == CH_SLS && st_q.rt_cnt[g] >= SLS_BURST;
        endsequence
        sequence s_open_armed;
            st_q.ch[g] == CH_NORM && mon_c[g] && st_q.s2.diag_en &&
            st_q.s2.open_low[g] && !st_q.s2.open_high[g] &&
            !st_q.s2.sg_low[g] && st_q.op_cnt[g] == OPEN_TC - 1'b1;
        endsequence
        sequence s_sls_armed;
            st_q.ch[g] == CH_NORM && mon_c[g] && st_q.s2.diag_en &&
            st_q.s2.sls_low[g] && !st_q.s2.sls_high[g] &&
            !st_q.s2.sg_low[g] && !st_q.s2.open_low[g] &&
            st_q.sl_cnt[g] == SLS_TC - 1'b1;
        endsequence

        a_sg_detect: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            s_sg_armed |=> st_q.ch[g] == CH_SG && st_q.oe)
            else $error("ground short not flagged");
        a_sg_restart: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            st_q.ch[g] == CH_NORM && mon_c[g] && st_q.s2.sg_high[g]
            |=> st_q.sg_cnt[g] == '0)
            else $error("ground short timer not restarted");
        a_sg_retry: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            st_q.ch[g] == CH_SG && !goff_c |=> st_q.retry[g] && !st_q.on[g])
            else $error("ground retry current missing");
        a_sg_recover: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            s_sg_seen_high |=> st_q.ch[g] == CH_NORM)
            else $error("ground short not cleared");
        a_open_gate: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            st_q.ch[g] == CH_NORM && !(st_q.s2.diag_en && mon_c[g])
            |=> st_q.op_cnt[g] == '0 && st_q.sl_cnt[g] == '0)
            else $error("diagnostic counter ran while gated");
        a_sls_burst: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            s_sls_past_burst |=> !st_q.on[g])
            else $error("burst exceeded its length");
        a_sls_recover: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            st_q.ch[g] == CH_SLS && st_q.on[g] && st_q.s2.sls_high[g]
            |=> st_q.ch[g] == CH_NORM)
            else $error("single short not cleared");

        // open circuit, single short, diagnostics and dimming
        a_open_detect: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            s_open_armed |=> st_q.ch[g] == CH_OPEN && st_q.oe)
            else $error("open circuit not flagged");
        a_open_restart: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            st_q.ch[g] == CH_NORM && mon_c[g] && st_q.s2.open_high[g]
            |=> st_q.op_cnt[g] == '0)
            else $error("open timer not restarted");
        a_open_retry: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            st_q.ch[g] == CH_OPEN && st_q.s2.diag_en && !goff_c
            |=> st_q.retry[g] && !st_q.on[g])
            else $error("open retry current missing");
        a_open_recover: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            st_q.ch[g] == CH_OPEN && st_q.s2.open_high[g]
            |=> st_q.ch[g] == CH_NORM)
            else $error("open circuit not cleared");
        a_sls_detect: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            s_sls_armed |=> st_q.ch[g] == CH_SLS && st_q.oe)
            else $error("single short not flagged");
        a_sls_restart: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            st_q.ch[g] == CH_NORM && mon_c[g] && st_q.s2.sls_high[g]
            |=> st_q.sl_cnt[g] == '0)
            else $error("single short timer not restarted");
        a_diag_off: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            (st_q.ch[g] == CH_OPEN || st_q.ch[g] == CH_SLS) &&
            !st_q.s2.diag_en |=> st_q.ch[g] == CH_NORM)
            else $error("diagnostic fault kept with checks off");
        a_dim_off: assert property (@(posedge sys_clk_i)
            disable iff (!rst_n_i)
            !st_q.s2.dim[g] |=> !st_q.on[g])
            else $error("channel on with dimming low");
    end

    a_ref_set: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        st_q.s2.ref_short_low && st_q.rs_cnt == REF_TC - 1'b1
        |=> (st_q.ref_short && st_q.clamp && !st_q.analog_current_setting_pin && st_q.oe)
            ##1 (st_q.on == '0 && st_q.retry == '0))
        else $error("reference short not handled");
    a_ref_clear: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        st_q.ref_short && !st_q.s2.ref_short_low |=> !st_q.ref_short)
        else $error("reference short not cleared");
    a_refo_set: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        st_q.s2.ref_open_low && st_q.ro_cnt == REF_TC - 1'b1
        |=> (st_q.ref_open && !st_q.analog_current_setting_pin && st_q.oe)
            ##1 (st_q.on == '0 && st_q.retry == '0))
        else $error("reference open not handled");
    a_refo_clear: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        st_q.ref_open && !st_q.s2.ref_open_low |=> !st_q.ref_open)
        else $error("reference open not cleared");
    a_ext_bus_off: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        st_q.ext |=> st_q.on == '0 && st_q.retry == '0)
        else $error("outputs on while bus held low");
    // shared fault line and over-temperature
    a_ext_detect: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        !st_q.s2.fault_line && !st_q.oe && st_q.oe_hist == '0
        |=> st_q.ext)
        else $error("external bus low not seen");
    a_ext_release: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        st_q.s2.fault_line |=> !st_q.ext)
        else $error("external bus low kept after release");
    a_otemp_off: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        st_q.s2.overtemp |=> st_q.oe && st_q.on == '0 && st_q.retry == '0)
        else $error("over-temperature not handled");

endmodule

// File: tb/lcfs_led_model.sv
`timescale 1ns/1ps
// led strings and shared fault bus seen from the supervisor comparators
module lcfs_led_model
    import lcfs_pkg::*;
(
    input wire logic [NCH-1:0] sg_flt_i,
    input wire logic [NCH-1:0] op_flt_i,
    input wire logic [NCH-1:0] sl_flt_i,
    input wire logic ext_pull_i,
    input wire logic fault_line_oe_i,
    output logic [NCH-1:0] sg_low_o,
    output logic [NCH-1:0] sg_high_o,
    output logic [NCH-1:0] open_low_o,
    output logic [NCH-1:0] open_high_o,
    output logic [NCH-1:0] sls_low_o,
    output logic [NCH-1:0] sls_high_o,
    output logic fault_line_o
);
    // a shorted string holds main or sharing output low, retry or not
    assign sg_low_o = sg_flt_i;
    assign sg_high_o = ~sg_flt_i;
    // open string or short to battery both collapse the headroom
    assign open_low_o = op_flt_i;
    assign open_high_o = ~op_flt_i;
    // a shorted led lowers the scaled output
    assign sls_low_o = sl_flt_i;
    assign sls_high_o = ~sl_flt_i;
    // pulled-up bus, low while any party sinks it
    assign fault_line_o = ~(fault_line_oe_i | ext_pull_i);
endmodule

// File: tb/test_lcfs_supervisor.sv
`timescale 1ns/1ps
module test_lcfs_supervisor
    import lcfs_pkg::*;
;
    logic sys_clk, rst_n, ref_s, ref_o, otemp, diag, ext_pull;
    logic [NCH-1:0] dim, sg_f, op_f, sl_f, sgl, sgh, opl, oph, sll, slh;
    logic line, fl_val, oe, analog_current_setting_pin, clamp;
    logic [NCH-1:0] chan_on, retry;
    lcfs_cmp_t cmp;
    lcfs_stat_t stat;
    int num_errors, tests_run, cyc, cnt;

    // clock generation
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // comparator bundle
    always_comb begin
        cmp = '0;
        cmp.ref_short_low = ref_s;
        cmp.ref_open_low = ref_o;
        cmp.overtemp = otemp;
        cmp.diag_en = diag;
        cmp.fault_line = line;
        cmp.dim = dim;
        cmp.sg_low = sgl;
        cmp.sg_high = sgh;
        cmp.open_low = opl;
        cmp.open_high = oph;
        cmp.sls_low = sll;
        cmp.sls_high = slh;
    end

    lcfs_supervisor #(.REF_TC(CW'(4)), .SG_TC(CW'(4)), .OPEN_TC(CW'(4)),
        .SLS_TC(CW'(4)), .SLS_PERIOD(CW'(40)), .SLS_BURST(CW'(12))) dut_u (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .cmp_i(cmp),
        .chan_on_o(chan_on), .retry_on_o(retry), .analog_current_setting_pin_on_o(analog_current_setting_pin),
        .ref_clamp_o(clamp), .fault_line_o(fl_val),
        .fault_line_oe_o(oe), .status_o(stat));

    lcfs_led_model led_u (
        .sg_flt_i(sg_f), .op_flt_i(op_f), .sl_flt_i(sl_f),
        .ext_pull_i(ext_pull), .fault_line_oe_i(oe),
        .sg_low_o(sgl), .sg_high_o(sgh), .open_low_o(opl),
        .open_high_o(oph), .sls_low_o(sll), .sls_high_o(slh),
        .fault_line_o(line));

    // compare and count
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // short fault pulse on channel 0 of one kind
    task automatic pulse(input int k, input int n);
        if (k == 0) sg_f[0] = 1'b1;
        if (k == 1) op_f[0] = 1'b1;
        if (k == 2) sl_f[0] = 1'b1;
        step(n);
        sg_f = '0;
        op_f = '0;
        sl_f = '0;
    endtask

    // cycles with full current on channel 2 over one retry period
    task automatic count_on();
        cnt = 0;
        repeat (40) begin
            @(negedge sys_clk);
            cnt += int'(chan_on[2]);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 6000) begin
            num_errors++;
            print_verdict();
        end
    end

    initial begin
        {ref_s, ref_o, otemp, ext_pull, rst_n} = '0;
        {sg_f, op_f, sl_f} = '0;
        diag = 1'b0;
        dim = 3'h7;
        num_errors = 0;
        tests_run = 0;
        cyc = 0;
        step(5);
        rst_n = 1'b1;
        step(12);
        chk("chan_on", 16'h0007, 16'(chan_on));
        chk("idle", 16'h0001, {11'h000, retry, oe, analog_current_setting_pin});
        chk("idle stat", 16'h0000, 16'(stat));
        chk("line val", 16'h0000, 16'(fl_val));
        // dimmed channel has no current and no ground check
        dim = 3'h6;
        sg_f[0] = 1'b1;
        step(12);
        chk("dim off", 16'h0006, 16'(chan_on));
        chk("sg dim", 16'h0000, 16'(stat.sg));
        dim = 3'h7;
        step(12);
        chk("sg flag", 16'h0001, 16'(stat.sg));
        dim = 3'h6;
        step(4);
        chk("sg out", 16'h004E, 16'({oe, retry, chan_on}));
        sg_f = '0;
        dim = 3'h7;
        step(12);
        chk("sg gone", 16'h0038, 16'({oe, retry, chan_on, stat.sg}));
        // two short glitches one cycle apart; only a restart keeps them apart
        diag = 1'b1;
        for (int k = 0; k < 3; k++) begin
            pulse(k, 3);
            step(1);
            pulse(k, 3);
            step(12);
            chk("glitch", 16'h0000, 16'(stat));
        end
        // open check needs diagnostics enabled
        diag = 1'b0;
        op_f[1] = 1'b1;
        step(12);
        chk("open off", 16'h0000, 16'(stat.open));
        diag = 1'b1;
        step(12);
        chk("open flag", 16'h0002, 16'(stat.open));
        chk("open out", 16'h0055, 16'({oe, retry, chan_on}));
        op_f = '0;
        step(12);
        chk("open gone", 16'h0038,
            16'({oe, retry, chan_on, stat.open}));
        // single led short with burst retry
        sl_f[2] = 1'b1;
        step(12);
        chk("sls flag", 16'h0104, 16'({oe, 5'h00, stat.sls}));
        count_on();
        chk("burst", 16'h000C, 16'(cnt));
        dim = 3'h3;
        step(3);
        count_on();
        chk("burst dim", 16'h0000, 16'(cnt));
        dim = 3'h7;
        sl_f = '0;
        step(50);
        chk("sls gone", 16'h0038, 16'({oe, chan_on, stat.sls}));
        // global faults: ref short, ref open, overtemp, external bus low
        for (int g = 0; g < 4; g++) begin
            ref_s = (g == 0);
            ref_o = (g == 1);
            otemp = (g == 2);
            ext_pull = (g == 3);
            step(12);
            chk("glob on", 16'h0000, 16'(chan_on));
            chk("glob oe", 16'((g != 3)), 16'(oe));
            chk("clamp", 16'((g == 0)), 16'(clamp));
            chk("glob flags", 16'({g == 0, g == 1, g == 3}),
                16'({stat.ref_short, stat.ref_open, stat.ext_bus_low}));
            if (g < 2) chk("analog_current_setting_pin", 16'h0000, 16'(analog_current_setting_pin));
            {ref_s, ref_o, otemp, ext_pull} = '0;
            step(12);
            chk("glob back", 16'h000F, 16'({oe, analog_current_setting_pin, chan_on}));
        end
        print_verdict();
    end
endmodule
